/* File: spp_host.v */
`timescale 1ns/1ps
`include "spp_consts.vh"

// Operation
// [RULE1] Reset held low during whole session; an enable in session pulses it high in S_PULS
// [RULE2] Programming enable sent before other instructions
// [RULE3] Device samples data on rising SCK
// [RULE4] Device changes output on falling SCK
// [RULE5] SCK phases longer than device minimum
// [RULE6] Reset and SCK low at power-up
// [RULE7] Wait 20 ms before programming enable
// [RULE8] Device echoes $53 during third byte
// [RULE9] Send whole enable frame; retry on bad echo
// [RULE10] Page loaded bytewise, low byte first
// [RULE11] Write-page commits page by high address
// [RULE12] Wait 4.5 ms after page write
// [RULE13] EEPROM write self-erases the location
// [RULE14] EEPROM bytewise; wait 9.0 ms after each
// [RULE15] Chip erase sets everything to $FF
// [RULE16] Read returns selected memory content
// [RULE17] Flash page reads $FF while busy
// [RULE18] EEPROM byte reads $FF while busy
// [RULE19] Polling fails for $FF; use wait
// [RULE20] Release reset high to end session
// [RULE21] Enable encoded AC 53 xx xx
// [RULE22] Chip erase encoded AC 100x xxxx
// [RULE23] Write-page encoded 4C, address bytes two, three
// [RULE24] MSB first; data returned in byte four
// [RULE25] Device samples SCK with own clock
module spp_host #(
  parameter PWRUP_WAIT  = `SPP_PWRUP_WAIT_CYC,
  parameter FLASH_WAIT  = `SPP_FLASH_WAIT_CYC,
  parameter EEPROM_WAIT = `SPP_EEPROM_WAIT_CYC,
  parameter ERASE_WAIT  = `SPP_ERASE_WAIT_CYC,
  parameter RETRIES     = 4
) (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        RSTN_IN,
  // Command port
  input  wire        CMD_VALID_IN,
  input  wire [2:0]  CMD_OP_IN,
  input  wire [9:0]  CMD_ADDR_IN,
  input  wire        CMD_HIGH_IN,
  input  wire [7:0]  CMD_DATA_IN,
  input  wire        CMD_POLL_IN,
  output reg         CMD_READY_OUT,
  output reg         RSP_VALID_OUT,
  output reg  [7:0]  RSP_DATA_OUT,
  output reg         RSP_ERR_OUT,
  output reg         SESSION_OUT,
  // Target pins
  output reg         TGT_RESET_OUT,
  output reg         TGT_SCK_OUT,
  output reg         TGT_MOSI_OUT,
  input  wire        TGT_MISO_IN
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PWR  = 7'h02;
  localparam [6:0] S_SEND = 7'h04;
  localparam [6:0] S_WAIT = 7'h08;
  localparam [6:0] S_POLL = 7'h10;
  localparam [6:0] S_RDY  = 7'h20;
  localparam [6:0] S_PULS = 7'h40;

  reg  [6:0]  st_q;
  reg  [31:0] tmr_q;
  reg  [7:0]  tries_q;
  reg  [2:0]  op_q;
  reg  [9:0]  addr_q;
  reg         high_q;
  reg  [7:0]  data_q;
  reg         poll_q;
  reg         poll_rd_q;
  reg         start_q;
  reg  [31:0] frame_q;
  reg         enabled_q;
  reg         miso_s1_q;
  reg         miso_s2_q;
  wire        sck_w;
  wire        mosi_w;
  wire        busy_w;
  wire        done_w;
  wire [31:0] rx_w;

  // Builds a frame for an operation
  function [31:0] mk_frame;
    input [2:0] op;
    input [9:0] a;
    input       h;
    input [7:0] d;
    begin
      case (op)
        `SPP_OP_ENABLE:       mk_frame = {`SPP_B1_ENABLE, `SPP_B2_ENABLE, 16'h0000}; // [RULE21]
        `SPP_OP_ERASE:        mk_frame = {`SPP_B1_ENABLE, `SPP_B2_ERASE, 16'h0000};  // [RULE22]
        `SPP_OP_LOAD_PAGE:    mk_frame = {`SPP_B1_LOAD_PAGE | (h ? `SPP_HBIT : `SPP_FILL),
                                          8'h00, 4'h0, a[3:0], d};                   // [RULE10]
        `SPP_OP_WRITE_PAGE:   mk_frame = {`SPP_B1_WRITE_PAGE, 6'h00, a[9:8],
                                          a[7:4], 4'h0, 8'h00};                      // [RULE11] [RULE23]
        `SPP_OP_READ_FLASH:   mk_frame = {`SPP_B1_READ_FLASH | (h ? `SPP_HBIT : `SPP_FILL),
                                          6'h00, a[9:8], a[7:0], `SPP_FILL};
        `SPP_OP_READ_EEPROM:  mk_frame = {`SPP_B1_READ_EEPROM, 8'h00, 1'b0, a[6:0], `SPP_FILL};
        `SPP_OP_WRITE_EEPROM: mk_frame = {`SPP_B1_WRITE_EEPROM, 8'h00, 1'b0, a[6:0], d}; // [RULE14]
        default:              mk_frame = 32'h0000_0000;
      endcase
    end
  endfunction

  spp_shifter u_shift (
    .clk    (CLK_IN),
    .rstn   (RSTN_IN),
    .start  (start_q),
    .frame  (frame_q),
    .miso   (miso_s2_q),
    .sck_q  (sck_w),
    .mosi_q (mosi_w),
    .busy_q (busy_w),
    .done_q (done_w),
    .rx_q   (rx_w)
  );

  always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      miso_s1_q     <= 1'b0;
      miso_s2_q     <= 1'b0;
      TGT_SCK_OUT   <= 1'b0;
      TGT_MOSI_OUT  <= 1'b0;
      TGT_RESET_OUT <= 1'b0;                    // [RULE6]
    end else begin
      miso_s1_q     <= TGT_MISO_IN;
      miso_s2_q     <= miso_s1_q;
      TGT_SCK_OUT   <= sck_w;
      TGT_MOSI_OUT  <= mosi_w;
      TGT_RESET_OUT <= (st_q == S_PULS) || (st_q == S_IDLE); // [RULE1] [RULE20]
    end
  end

  always @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      st_q          <= S_IDLE;
      tmr_q         <= 32'h0000_0000;
      tries_q       <= 8'h00;
      op_q          <= `SPP_OP_END;
      addr_q        <= 10'h000;
      high_q        <= 1'b0;
      data_q        <= 8'h00;
      poll_q        <= 1'b0;
      poll_rd_q     <= 1'b0;
      start_q       <= 1'b0;
      frame_q       <= 32'h0000_0000;
      enabled_q     <= 1'b0;
      CMD_READY_OUT <= 1'b0;
      RSP_VALID_OUT <= 1'b0;
      RSP_DATA_OUT  <= 8'h00;
      RSP_ERR_OUT   <= 1'b0;
      SESSION_OUT   <= 1'b0;
    end else begin
      start_q       <= 1'b0;
      RSP_VALID_OUT <= 1'b0;
      CMD_READY_OUT <= (st_q == S_IDLE) || (st_q == S_RDY);
      SESSION_OUT   <= enabled_q;
      case (st_q)
        S_IDLE: begin
          if (CMD_VALID_IN && CMD_READY_OUT && CMD_OP_IN == `SPP_OP_ENABLE) begin
            CMD_READY_OUT <= 1'b0;
            st_q    <= S_PWR;
            tmr_q   <= PWRUP_WAIT;              // [RULE7]
            tries_q <= RETRIES[7:0];
            op_q    <= `SPP_OP_ENABLE;
          end else if (CMD_VALID_IN && CMD_READY_OUT) begin
            CMD_READY_OUT <= 1'b0;
            RSP_VALID_OUT <= 1'b1;
            RSP_ERR_OUT   <= 1'b1;              // [RULE2]
          end
        end
        S_PWR: begin
          if (tmr_q == 32'h0000_0000) begin
            st_q    <= S_SEND;
            start_q <= 1'b1;
            frame_q <= mk_frame(`SPP_OP_ENABLE, 10'h000, 1'b0, 8'h00);
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        S_PULS: begin
          if (tmr_q == 32'h0000_0000) begin
            st_q  <= S_PWR;
            tmr_q <= PWRUP_WAIT;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        S_SEND: begin
          if (done_w) begin
            if (op_q == `SPP_OP_ENABLE) begin
              if (rx_w[15:8] == `SPP_B2_ENABLE) begin // [RULE8] [RULE9]
                enabled_q     <= 1'b1;
                RSP_VALID_OUT <= 1'b1;
                RSP_ERR_OUT   <= 1'b0;
                st_q          <= S_RDY;
              end else if (tries_q == 8'h00) begin
                enabled_q     <= 1'b0;
                RSP_VALID_OUT <= 1'b1;
                RSP_ERR_OUT   <= 1'b1;
                st_q          <= S_IDLE;
              end else begin
                tries_q <= tries_q - 8'h01;
                tmr_q   <= {24'h000000, `SPP_RST_PULSE_CYC}; // [RULE6]
                st_q    <= S_PULS;
              end
            end else if (poll_rd_q) begin
              // Polled write: read back until value matches [RULE17] [RULE18]
              if (rx_w[7:0] == data_q) begin
                RSP_VALID_OUT <= 1'b1;
                RSP_ERR_OUT   <= 1'b0;
                st_q          <= S_RDY;
              end else begin
                st_q <= S_POLL;
              end
            end else if (op_q == `SPP_OP_READ_FLASH || op_q == `SPP_OP_READ_EEPROM) begin
              RSP_VALID_OUT <= 1'b1;
              RSP_DATA_OUT  <= rx_w[7:0];       // [RULE16] [RULE24]
              RSP_ERR_OUT   <= 1'b0;
              st_q          <= S_RDY;
            end else if (op_q == `SPP_OP_WRITE_EEPROM) begin
              // Polling cannot see $FF, so that value always waits [RULE19]
              if (poll_q && data_q != `SPP_ERASED) begin
                st_q <= S_POLL;
              end else begin
                tmr_q <= EEPROM_WAIT;           // [RULE13] [RULE14]
                st_q  <= S_WAIT;
              end
            end else if (op_q == `SPP_OP_WRITE_PAGE) begin
              if (poll_q && data_q != `SPP_ERASED) begin
                st_q <= S_POLL;
              end else begin
                tmr_q <= FLASH_WAIT;            // [RULE12]
                st_q  <= S_WAIT;
              end
            end else if (op_q == `SPP_OP_ERASE) begin
              tmr_q <= ERASE_WAIT;              // [RULE15]
              st_q  <= S_WAIT;
            end else begin
              RSP_VALID_OUT <= 1'b1;
              RSP_ERR_OUT   <= 1'b0;
              st_q          <= S_RDY;
            end
          end
        end
        S_POLL: begin
          poll_rd_q <= 1'b1;
          start_q   <= 1'b1;
          st_q      <= S_SEND;
          frame_q   <= mk_frame(op_q == `SPP_OP_WRITE_EEPROM ? `SPP_OP_READ_EEPROM
                                : `SPP_OP_READ_FLASH, addr_q, high_q, 8'h00);
        end
        S_WAIT: begin
          if (tmr_q == 32'h0000_0000) begin
            RSP_VALID_OUT <= 1'b1;
            RSP_ERR_OUT   <= 1'b0;
            st_q          <= S_RDY;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        S_RDY: begin
          poll_rd_q <= 1'b0;
          if (CMD_VALID_IN && CMD_READY_OUT) begin
            CMD_READY_OUT <= 1'b0;
            op_q   <= CMD_OP_IN;
            addr_q <= CMD_ADDR_IN;
            high_q <= CMD_HIGH_IN;
            data_q <= CMD_DATA_IN;
            poll_q <= CMD_POLL_IN;
            if (CMD_OP_IN == `SPP_OP_END) begin
              enabled_q     <= 1'b0;
              RSP_VALID_OUT <= 1'b1;
              RSP_ERR_OUT   <= 1'b0;
              st_q          <= S_IDLE;          // [RULE20]
            end else if (CMD_OP_IN == `SPP_OP_ENABLE) begin
              tmr_q   <= {24'h000000, `SPP_RST_PULSE_CYC};
              tries_q <= RETRIES[7:0];
              st_q    <= S_PULS;
            end else begin
              start_q <= 1'b1;
              frame_q <= mk_frame(CMD_OP_IN, CMD_ADDR_IN, CMD_HIGH_IN, CMD_DATA_IN);
              st_q    <= S_SEND;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: spp_consts.vh */
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH

`define SPP_CLK_MHZ          25
`define SPP_CLK_PERIOD_NS    40
`define SPP_SCK_HALF_CYC     8'h04
`define SPP_RST_PULSE_CYC    8'h04
`define SPP_PWRUP_WAIT_US    20000
`define SPP_FLASH_WAIT_US    4500
`define SPP_EEPROM_WAIT_US   9000
`define SPP_ERASE_WAIT_US    9000
`define SPP_PWRUP_WAIT_CYC   (`SPP_PWRUP_WAIT_US * `SPP_CLK_MHZ)
`define SPP_FLASH_WAIT_CYC   (`SPP_FLASH_WAIT_US * `SPP_CLK_MHZ)
`define SPP_EEPROM_WAIT_CYC  (`SPP_EEPROM_WAIT_US * `SPP_CLK_MHZ)
`define SPP_ERASE_WAIT_CYC   (`SPP_ERASE_WAIT_US * `SPP_CLK_MHZ)

`define SPP_OP_ENABLE        3'h0
`define SPP_OP_ERASE         3'h1
`define SPP_OP_LOAD_PAGE     3'h2
`define SPP_OP_WRITE_PAGE    3'h3
`define SPP_OP_READ_FLASH    3'h4
`define SPP_OP_READ_EEPROM   3'h5
`define SPP_OP_WRITE_EEPROM  3'h6
`define SPP_OP_END           3'h7

`define SPP_B1_ENABLE        8'hAC
`define SPP_B2_ENABLE        8'h53
`define SPP_B2_ERASE         8'h80
`define SPP_B1_LOAD_PAGE     8'h40
`define SPP_B1_WRITE_PAGE    8'h4C
`define SPP_B1_READ_FLASH    8'h20
`define SPP_B1_READ_EEPROM   8'hA0
`define SPP_B1_WRITE_EEPROM  8'hC0
`define SPP_HBIT             8'h08
`define SPP_FILL             8'h00
`define SPP_ERASED           8'hFF

`endif

/* File: spp_shifter.v */
`timescale 1ns/1ps
`include "spp_consts.vh"

// Shifts one 32-bit frame MSB first; SCK is made by dividing CLK_IN
module spp_shifter #(
  parameter HALF = `SPP_SCK_HALF_CYC
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        start,
  input  wire [31:0] frame,
  input  wire        miso,
  output reg         sck_q,
  output reg         mosi_q,
  output reg         busy_q,
  output reg         done_q,
  output reg  [31:0] rx_q
);
  reg [7:0]  cnt_q;
  reg [5:0]  bits_q;
  reg [31:0] tx_q;

  always @(posedge clk) begin
    if (!rstn) begin
      sck_q  <= 1'b0;
      mosi_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rx_q   <= 32'h0000_0000;
      cnt_q  <= 8'h00;
      bits_q <= 6'h00;
      tx_q   <= 32'h0000_0000;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          busy_q <= 1'b1;
          tx_q   <= {frame[30:0], 1'b0};
          mosi_q <= frame[31];                  // [RULE24]
          bits_q <= 6'h20;
          cnt_q  <= 8'h00;
        end
      end else if (cnt_q == HALF - 8'h01) begin  // [RULE5]
        cnt_q <= 8'h00;
        if (!sck_q) begin
          sck_q <= 1'b1;                        // [RULE3]
          rx_q  <= {rx_q[30:0], miso};          // [RULE4]
        end else begin
          sck_q  <= 1'b0;
          bits_q <= bits_q - 6'h01;
          mosi_q <= tx_q[31];
          tx_q   <= {tx_q[30:0], 1'b0};
          if (bits_q == 6'h01) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            mosi_q <= 1'b0;
          end
        end
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule

/* File: spp_host_asserts.sv */
`timescale 1ns/1ps
module spp_host_asserts #(
  parameter PWRUP_WAIT = 50
) (
  input wire       CLK_IN,
  input wire       RSTN_IN,
  input wire       CMD_VALID_IN,
  input wire [2:0] CMD_OP_IN,
  input wire       CMD_READY_OUT,
  input wire       RSP_VALID_OUT,
  input wire       RSP_ERR_OUT,
  input wire       SESSION_OUT,
  input wire       TGT_RESET_OUT,
  input wire       TGT_SCK_OUT,
  input wire       TGT_MOSI_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  wire       take = CMD_VALID_IN && CMD_READY_OUT;
  reg [31:0] gap_q;
  // Cycles since the target entered programming
  always @(posedge CLK_IN)
    if (TGT_RESET_OUT) gap_q <= 32'h0;
    else if (gap_q != 32'hFFFFFFFF) gap_q <= gap_q + 32'h1;
  sck_idle_a: assert property (TGT_RESET_OUT |-> !TGT_SCK_OUT)
    else $error("clock active while target released");
  enable_rst_a: assert property (take && CMD_OP_IN == 3'h0 |-> ##[1:8] !TGT_RESET_OUT)
    else $error("enable did not hold target reset");
  sess_rst_a: assert property ($rose(SESSION_OUT) |-> !TGT_RESET_OUT)
    else $error("session without target reset");
  refuse_op_a: assert property (take && !SESSION_OUT && CMD_OP_IN != 3'h0
    |-> ##[1:2] RSP_VALID_OUT && RSP_ERR_OUT) else $error("op outside session not refused");
  sck_high_a: assert property ($rose(TGT_SCK_OUT) |-> TGT_SCK_OUT[*4])
    else $error("clock high phase too short");
  sck_low_a: assert property ($fell(TGT_SCK_OUT) |-> !TGT_SCK_OUT[*4])
    else $error("clock low phase too short");
  mosi_hold_a: assert property ($changed(TGT_MOSI_OUT) |-> !TGT_SCK_OUT)
    else $error("data changed while clock high");
  pwrup_wait_a: assert property ($rose(TGT_SCK_OUT) |-> gap_q >= PWRUP_WAIT - 1)
    else $error("frame started before power-up wait");
  end_rel_a: assert property (take && SESSION_OUT && CMD_OP_IN == 3'h7
    |-> ##[1:4] TGT_RESET_OUT) else $error("end did not release target");
  cover property (RSP_VALID_OUT && RSP_ERR_OUT);
  cover property ($rose(SESSION_OUT));
  cover property (take && SESSION_OUT && CMD_OP_IN == 3'h3);
endmodule

bind spp_host spp_host_asserts #(.PWRUP_WAIT(PWRUP_WAIT)) u_chk (.CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN), .CMD_VALID_IN(CMD_VALID_IN), .CMD_OP_IN(CMD_OP_IN),
  .CMD_READY_OUT(CMD_READY_OUT), .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_ERR_OUT(RSP_ERR_OUT),
  .SESSION_OUT(SESSION_OUT), .TGT_RESET_OUT(TGT_RESET_OUT), .TGT_SCK_OUT(TGT_SCK_OUT),
  .TGT_MOSI_OUT(TGT_MOSI_OUT));

/* File: spp_dev.sv */
`timescale 1ns/1ps
// Behavioural target of the serial programming link
module spp_dev #(
  parameter BUSY = 600
) (
  // Clock
  input  wire clk_in,
  // Programming pins
  input  wire reset_in,
  input  wire sck_in,
  input  wire mosi_in,
  output reg  miso_out = 1'b0,
  // Fault control
  input  wire bad_echo_in
);
  reg [7:0]  fl [0:2047];
  reg [7:0]  ee [0:127];
  reg [7:0]  pb [0:31];
  reg [31:0] sh = 32'h0;
  reg [7:0]  tx = 8'h00;
  reg [4:0]  n = 5'h0;
  reg        en = 1'b0;
  reg [5:0]  bpg = 6'h0;
  reg [6:0]  bea = 7'h0;
  reg        bfl = 1'b0;
  integer    bsy = 0;
  integer    i;
  initial begin
    for (i = 0; i < 2048; i = i + 1) fl[i] = 8'h00;
    for (i = 0; i < 128; i = i + 1) ee[i] = 8'h00;
    for (i = 0; i < 32; i = i + 1) pb[i] = 8'hFF;
  end
  always @(posedge clk_in)
    if (bsy > 0) bsy = bsy - 1;
  // Leaving programming drops sync; the released line shows the inverse
  always @(posedge reset_in) begin
    n = 5'h0;
    en = 1'b0;
    miso_out = ~miso_out;
  end
  function [7:0] rd(input [23:0] c);
    if (c[23:16] == 8'hA0)
      rd = (bsy > 0 && !bfl && bea == c[6:0]) ? 8'hFF : ee[c[6:0]];
    else if ({c[23:20], c[18:16]} == 7'h10)
      rd = (bsy > 0 && bfl && bpg == c[9:4]) ? 8'hFF : fl[{c[9:0], c[19]}];
    else rd = 8'h00;
  endfunction
  task exec(input [31:0] f);
    integer j;
    begin
      if (f[31:16] == 16'hAC53) en = 1'b1;
      else if (en && f[31:24] == 8'hAC && f[23:21] == 3'h4) begin
        for (j = 0; j < 2048; j = j + 1) fl[j] = 8'hFF;
        for (j = 0; j < 128; j = j + 1) ee[j] = 8'hFF;
      end else if (en && f[31:24] == 8'h4C) begin
        bpg = {f[17:16], f[15:12]};
        for (j = 0; j < 32; j = j + 1) fl[{bpg, j[4:0]}] = pb[j];
        bfl = 1'b1;
        bsy = BUSY;
      end else if (en && {f[31:28], f[26:24]} == 7'h20) pb[{f[11:8], f[27]}] = f[7:0];
      else if (en && f[31:24] == 8'hC0) begin
        ee[f[14:8]] = f[7:0];
        bea = f[14:8];
        bfl = 1'b0;
        bsy = BUSY;
      end
    end
  endtask
  always @(negedge sck_in) begin
    miso_out = tx[7];
    tx = {tx[6:0], 1'b0};
  end
  always @(posedge sck_in) if (!reset_in) begin
    sh = {sh[30:0], mosi_in};
    if (n == 5'd15) tx = sh[7:0] ^ {8{bad_echo_in}};
    else if (n == 5'd23) tx = rd(sh[23:0]);
    else if (n[2:0] == 3'h7) tx = 8'h00;
    if (n == 5'd31) exec(sh);
    n = n + 5'h1;
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        vld = 1'b0;
  reg  [2:0] op = 3'h0;
  reg  [9:0] adr = 10'h000;
  reg        hi = 1'b0;
  reg  [7:0] dat = 8'h00;
  reg        pol = 1'b0;
  reg        bad = 1'b0;
  wire       rdy, rv, re, ses, trst, sck, mosi, miso;
  wire [7:0] rdat;
  reg  [7:0] got;
  reg        err;
  integer    n_mismatch = 0;
  integer    total_checks = 0;
  integer    cyc = 0;
  spp_host #(.PWRUP_WAIT(50), .FLASH_WAIT(700), .EEPROM_WAIT(700), .ERASE_WAIT(700),
    .RETRIES(2)) u_spp_host (.CLK_IN(clk), .RSTN_IN(rst_n), .CMD_VALID_IN(vld),
    .CMD_OP_IN(op), .CMD_ADDR_IN(adr), .CMD_HIGH_IN(hi), .CMD_DATA_IN(dat),
    .CMD_POLL_IN(pol), .CMD_READY_OUT(rdy), .RSP_VALID_OUT(rv), .RSP_DATA_OUT(rdat),
    .RSP_ERR_OUT(re), .SESSION_OUT(ses), .TGT_RESET_OUT(trst), .TGT_SCK_OUT(sck),
    .TGT_MOSI_OUT(mosi), .TGT_MISO_IN(miso));
  spp_dev u_spp_dev (.clk_in(clk), .reset_in(trst), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .bad_echo_in(bad));
  initial forever #20 clk = ~clk;
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  task chk8(input [7:0] g, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: byte %h want %h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: flag %b want %b", $time, g, e);
      end
    end
  endtask
  // Offer one command, wait for its single response
  task cmd(input [2:0] o, input [9:0] a, input h, input [7:0] d, input p);
    integer k;
    begin
      @(negedge clk);
      op = o;
      adr = a;
      hi = h;
      dat = d;
      pol = p;
      vld = 1'b1;
      while (rdy !== 1'b1) @(negedge clk);
      @(negedge clk);
      vld = 1'b0;
      k = 0;
      while (rv !== 1'b1 && k < 5000) begin
        @(negedge clk);
        k = k + 1;
      end
      @(negedge clk);
      got = rdat;
      err = re;
    end
  endtask
  task t_refuse;
    begin
      cmd(3'h4, 10'h001, 1'b0, 8'h00, 1'b0);
      chk1(err, 1'b1);
      chk1(ses, 1'b0);
    end
  endtask
  task t_enable;
    begin
      cmd(3'h0, 10'h000, 1'b0, 8'h00, 1'b0);
      chk1(err, 1'b0);
      chk1(ses, 1'b1);
      chk1(trst, 1'b0);
    end
  endtask
  task t_bad_echo;
    begin
      bad = 1'b1;
      cmd(3'h0, 10'h000, 1'b0, 8'h00, 1'b0);
      chk1(err, 1'b1);
      chk1(ses, 1'b0);
      bad = 1'b0;
    end
  endtask
  task t_erase;
    begin
      cmd(3'h1, 10'h000, 1'b0, 8'h00, 1'b0);
      cmd(3'h4, 10'h155, 1'b1, 8'h00, 1'b0);
      chk8(got, 8'hFF);
      cmd(3'h5, 10'h07F, 1'b0, 8'h00, 1'b0);
      chk8(got, 8'hFF);
    end
  endtask
  task t_flash;
    begin
      cmd(3'h2, 10'h123, 1'b0, 8'h3C, 1'b0);
      cmd(3'h2, 10'h123, 1'b1, 8'hC3, 1'b0);
      cmd(3'h3, 10'h123, 1'b0, 8'h3C, 1'b1);
      cmd(3'h4, 10'h123, 1'b0, 8'h00, 1'b0);
      chk8(got, 8'h3C);
      cmd(3'h4, 10'h123, 1'b1, 8'h00, 1'b0);
      chk8(got, 8'hC3);
      cmd(3'h2, 10'h2A0, 1'b0, 8'h55, 1'b0);
      cmd(3'h3, 10'h2A0, 1'b0, 8'h55, 1'b0);
      cmd(3'h4, 10'h2A0, 1'b0, 8'h00, 1'b0);
      chk8(got, 8'h55);
    end
  endtask
  task t_eeprom;
    begin
      cmd(3'h6, 10'h005, 1'b0, 8'h5A, 1'b1);
      cmd(3'h5, 10'h005, 1'b0, 8'h00, 1'b0);
      chk8(got, 8'h5A);
      cmd(3'h6, 10'h005, 1'b0, 8'hA5, 1'b0);
      cmd(3'h5, 10'h005, 1'b0, 8'h00, 1'b0);
      chk8(got, 8'hA5);
    end
  endtask
  task t_end;
    begin
      cmd(3'h7, 10'h000, 1'b0, 8'h00, 1'b0);
      chk1(ses, 1'b0);
      chk1(trst, 1'b1);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_refuse;
    t_bad_echo;
    t_enable;
    t_enable;
    t_erase;
    t_flash;
    t_eeprom;
    t_end;
    t_refuse;
    complete_run;
  end
endmodule
